// [logic/lsq_pkg.sv]
// Shared constants and types for the load/store queue scheduler
package lsq_pkg;
    localparam int            QUEUE_DEPTH = 12;
    localparam int            IDX_W       = 4;
    localparam int            ADDR_W      = 32;
    localparam int            ID_W        = 6;
    localparam int            RTAG_W      = 6;
    localparam int            SCAN_WIDTH  = 2;
    localparam int            AGU_PORTS   = 2;
    localparam logic [IDX_W-1:0] LAST_IDX = 4'hB;
    localparam logic [IDX_W:0]   FULL_CNT = 5'h0C;

    // Primitive memory operation kinds produced by splitting a macro_operation
    typedef enum logic [1:0] {
        LSQ_OP_NONE,
        LSQ_OP_LOAD,
        LSQ_OP_STORE,
        LSQ_OP_LOAD_STORE
    } lsq_kind_t;

    // Access width: narrow is 32-bit, wide is 64-bit
    typedef enum logic {
        LSQ_W32,
        LSQ_W64
    } lsq_width_t;
endpackage

// [logic/lsq_sched.sv]
// Load/store reorder queue with in-order dual scan and three-stage cache probe pipe
// Functional notes
// - Split memory macro operations into load, store, or combined load/store plus INTEGER_EXECUTION_UNIT op
// - Dispatch allocates control unit, reservation station and queue entry together
// - Twelve-entry queue written in program order at dispatch
// - Probe the data cache strictly in program order
// - Accept generated addresses in any order into their allocated entries
// - Scan-out frees the entry and enters probe stages two and three
// - At most two operations scanned per cycle
// - Pairs allowed: two 64-bit loads, load plus store, two 32-bit stores
// - Stages: scan cycle 8, transport cycle 9, access and forward cycle 10
// - Address generated this cycle is eligible for scan this cycle
// - Ready operation waits while an older one is still unscanned
// - Address generation waits for base or index producer result
// - Load-execute integer part starts the cycle after data forward
`timescale 1ns/1ns
module lsq_sched (
    input  wire logic                                            sys_clk,
    input  wire logic                                            rst_n,
    input  wire logic                                            disp_valid,
    input  wire lsq_pkg::lsq_kind_t                              disp_kind,
    input  wire lsq_pkg::lsq_width_t                             disp_width,
    input  wire logic                                            disp_exec,
    input  wire logic [lsq_pkg::ID_W-1:0]                        disp_id,
    input  wire logic                                            disp_src_ready,
    input  wire logic [lsq_pkg::RTAG_W-1:0]                      disp_src_tag,
    output logic                                                 disp_ready,
    output logic                                                 icu_alloc,
    output logic                                                 rs_alloc,
    input  wire logic                                            res_valid,
    input  wire logic [lsq_pkg::RTAG_W-1:0]                      res_tag,
    output logic                                                 agu_req_valid,
    output logic [lsq_pkg::IDX_W-1:0]                            agu_req_idx,
    input  wire logic                                            agu_req_ready,
    input  wire logic [lsq_pkg::AGU_PORTS-1:0]                   agu_done_valid,
    input  wire logic [lsq_pkg::AGU_PORTS-1:0][lsq_pkg::IDX_W-1:0]  agu_done_idx,
    input  wire logic [lsq_pkg::AGU_PORTS-1:0][lsq_pkg::ADDR_W-1:0] agu_done_addr,
    input  wire logic                                            dc_ready,
    output logic [lsq_pkg::SCAN_WIDTH-1:0]                       dc_req_valid,
    output logic [lsq_pkg::SCAN_WIDTH-1:0][lsq_pkg::ADDR_W-1:0]  dc_req_addr,
    output lsq_pkg::lsq_kind_t [lsq_pkg::SCAN_WIDTH-1:0]         dc_req_kind,
    output lsq_pkg::lsq_width_t [lsq_pkg::SCAN_WIDTH-1:0]        dc_req_width,
    output logic [lsq_pkg::SCAN_WIDTH-1:0][lsq_pkg::ID_W-1:0]    dc_req_id,
    output logic [lsq_pkg::SCAN_WIDTH-1:0]                       fwd_valid,
    output logic [lsq_pkg::SCAN_WIDTH-1:0][lsq_pkg::ID_W-1:0]    fwd_id,
    output logic [lsq_pkg::SCAN_WIDTH-1:0]                       ieu_start,
    output logic [lsq_pkg::SCAN_WIDTH-1:0][lsq_pkg::ID_W-1:0]    ieu_id
);
    localparam int D = lsq_pkg::QUEUE_DEPTH;
    localparam int S = lsq_pkg::SCAN_WIDTH;

    function automatic logic [lsq_pkg::IDX_W-1:0] wrap_inc(
        input logic [lsq_pkg::IDX_W-1:0] idx
    );
        wrap_inc = (idx == lsq_pkg::LAST_IDX) ? '0 : idx + 4'h1;
    endfunction

    function automatic logic is_store(input lsq_pkg::lsq_kind_t k);
        is_store = (k == lsq_pkg::LSQ_OP_STORE) || (k == lsq_pkg::LSQ_OP_LOAD_STORE);
    endfunction

    // Combined load/store counts as a store, which is the stricter side of pairing
    function automatic logic pair_ok(
        input lsq_pkg::lsq_kind_t  ka,
        input lsq_pkg::lsq_width_t wa,
        input lsq_pkg::lsq_kind_t  kb,
        input lsq_pkg::lsq_width_t wb
    );
        if (!is_store(ka) && !is_store(kb)) begin
            pair_ok = 1'b1;
        end else if (is_store(ka) != is_store(kb)) begin
            pair_ok = 1'b1;
        end else begin
            pair_ok = (wa == lsq_pkg::LSQ_W32) && (wb == lsq_pkg::LSQ_W32);
        end
    endfunction

    // Queue state
    logic [D-1:0]                              q_valid,  next_q_valid;
    lsq_pkg::lsq_kind_t [D-1:0]                q_kind,   next_q_kind;
    lsq_pkg::lsq_width_t [D-1:0]               q_width,  next_q_width;
    logic [D-1:0]                              q_exec,   next_q_exec;
    logic [D-1:0][lsq_pkg::ID_W-1:0]           q_id,     next_q_id;
    logic [D-1:0]                              q_wait,   next_q_wait;
    logic [D-1:0][lsq_pkg::RTAG_W-1:0]         q_src,    next_q_src;
    logic [D-1:0]                              q_issued, next_q_issued;
    logic [D-1:0]                              q_addr_v, next_q_addr_v;
    logic [D-1:0][lsq_pkg::ADDR_W-1:0]         q_addr,   next_q_addr;
    logic [lsq_pkg::IDX_W-1:0]                 head,     next_head;
    logic [lsq_pkg::IDX_W-1:0]                 tail,     next_tail;
    logic [lsq_pkg::IDX_W:0]                   count,    next_count;

    // Pipe state: st2 is the transport stage, st3 the access and forward stage
    logic [S-1:0]                              st2_valid, next_st2_valid;
    logic [S-1:0][lsq_pkg::ADDR_W-1:0]         st2_addr,  next_st2_addr;
    lsq_pkg::lsq_kind_t [S-1:0]                st2_kind,  next_st2_kind;
    lsq_pkg::lsq_width_t [S-1:0]               st2_width, next_st2_width;
    logic [S-1:0]                              st2_exec,  next_st2_exec;
    logic [S-1:0][lsq_pkg::ID_W-1:0]           st2_id,    next_st2_id;
    logic [S-1:0]                              st3_valid, next_st3_valid;
    logic [S-1:0]                              st3_exec,  next_st3_exec;
    logic [S-1:0][lsq_pkg::ID_W-1:0]           st3_id,    next_st3_id;
    logic [S-1:0]                              ex_valid,  next_ex_valid;
    logic [S-1:0][lsq_pkg::ID_W-1:0]           ex_id,     next_ex_id;

    logic [D-1:0]                              eligible;
    logic [D-1:0][lsq_pkg::ADDR_W-1:0]         eff_addr;
    logic [lsq_pkg::IDX_W-1:0]                 scan_idx [S];
    logic [S-1:0]                              take;
    logic                                      accept;
    logic [lsq_pkg::IDX_W-1:0]                 probe;
    logic                                      found;

    always_comb begin
        next_q_valid  = q_valid;
        next_q_kind   = q_kind;
        next_q_width  = q_width;
        next_q_exec   = q_exec;
        next_q_id     = q_id;
        next_q_wait   = q_wait;
        next_q_src    = q_src;
        next_q_issued = q_issued;
        next_q_addr_v = q_addr_v;
        next_q_addr   = q_addr;
        next_head     = head;
        next_tail     = tail;
        next_count    = count;
        eligible      = '0;
        eff_addr      = q_addr;
        take          = '0;
        probe         = head;
        found         = 1'b0;
        agu_req_idx   = head;
        disp_ready    = (count != lsq_pkg::FULL_CNT);
        accept        = disp_valid && disp_ready && (disp_kind != lsq_pkg::LSQ_OP_NONE);
        icu_alloc     = accept;
        rs_alloc      = accept;
        // Producer results release waiting address generation
        for (int i = 0; i < D; i++) begin
            if (q_valid[i] && q_wait[i] && res_valid && (res_tag == q_src[i])) begin
                next_q_wait[i] = 1'b0;
            end
        end
        // Addresses arrive from either unit in any order
        for (int p = 0; p < lsq_pkg::AGU_PORTS; p++) begin
            if (agu_done_valid[p]) begin
                next_q_addr_v[agu_done_idx[p]] = 1'b1;
                next_q_addr[agu_done_idx[p]]   = agu_done_addr[p];
                eff_addr[agu_done_idx[p]]      = agu_done_addr[p];
            end
        end
        for (int i = 0; i < D; i++) begin
            eligible[i] = q_valid[i] && next_q_addr_v[i];
        end
        // Only the two oldest entries are looked at, so a young ready entry never passes
        scan_idx[0] = head;
        scan_idx[1] = wrap_inc(head);
        take[0] = dc_ready && eligible[scan_idx[0]];
        take[1] = take[0] && eligible[scan_idx[1]]
            && pair_ok(q_kind[scan_idx[0]], q_width[scan_idx[0]],
                       q_kind[scan_idx[1]], q_width[scan_idx[1]]);
        for (int s = 0; s < S; s++) begin
            if (take[s]) begin
                next_q_valid[scan_idx[s]] = 1'b0;
            end
        end
        next_head = take[1] ? wrap_inc(wrap_inc(head)) : (take[0] ? wrap_inc(head) : head);
        // Oldest entry whose operands are ready gets the next address generation slot
        for (int k = 0; k < D; k++) begin
            if (!found && q_valid[probe] && !q_wait[probe] && !q_issued[probe]
                && !q_addr_v[probe]) begin
                found       = 1'b1;
                agu_req_idx = probe;
            end
            probe = wrap_inc(probe);
        end
        agu_req_valid = found;
        if (found && agu_req_ready) begin
            next_q_issued[agu_req_idx] = 1'b1;
        end
        // Allocation at the tail keeps program order
        if (accept) begin
            next_q_valid[tail]  = 1'b1;
            next_q_kind[tail]   = disp_kind;
            next_q_width[tail]  = disp_width;
            next_q_exec[tail]   = disp_exec || (disp_kind == lsq_pkg::LSQ_OP_LOAD_STORE);
            next_q_id[tail]     = disp_id;
            next_q_src[tail]    = disp_src_tag;
            next_q_wait[tail]   = !(disp_src_ready || (res_valid && res_tag == disp_src_tag));
            next_q_issued[tail] = 1'b0;
            next_q_addr_v[tail] = 1'b0;
            next_tail           = wrap_inc(tail);
        end
        next_count = count + {4'h0, accept} - {4'h0, take[0]} - {4'h0, take[1]};
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            q_valid  <= '0;
            q_kind   <= '{default: lsq_pkg::LSQ_OP_NONE};
            q_width  <= '{default: lsq_pkg::LSQ_W32};
            q_exec   <= '0;
            q_id     <= '0;
            q_wait   <= '0;
            q_src    <= '0;
            q_issued <= '0;
            q_addr_v <= '0;
            q_addr   <= '0;
            head     <= '0;
            tail     <= '0;
            count    <= '0;
        end else begin
            q_valid  <= next_q_valid;
            q_kind   <= next_q_kind;
            q_width  <= next_q_width;
            q_exec   <= next_q_exec;
            q_id     <= next_q_id;
            q_wait   <= next_q_wait;
            q_src    <= next_q_src;
            q_issued <= next_q_issued;
            q_addr_v <= next_q_addr_v;
            q_addr   <= next_q_addr;
            head     <= next_head;
            tail     <= next_tail;
            count    <= next_count;
        end
    end

    // Probe pipe: scan, then transport, then access with forward, then integer start
    always_comb begin
        for (int s = 0; s < S; s++) begin
            next_st2_valid[s] = take[s];
            next_st2_addr[s]  = eff_addr[scan_idx[s]];
            next_st2_kind[s]  = q_kind[scan_idx[s]];
            next_st2_width[s] = q_width[scan_idx[s]];
            next_st2_exec[s]  = q_exec[scan_idx[s]];
            next_st2_id[s]    = q_id[scan_idx[s]];
        end
        next_st3_valid = st2_valid;
        next_st3_exec  = st2_exec;
        next_st3_id    = st2_id;
        next_ex_valid  = st3_valid & st3_exec;
        next_ex_id     = st3_id;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st2_valid <= '0;
            st2_addr  <= '0;
            st2_kind  <= '{default: lsq_pkg::LSQ_OP_NONE};
            st2_width <= '{default: lsq_pkg::LSQ_W32};
            st2_exec  <= '0;
            st2_id    <= '0;
            st3_valid <= '0;
            st3_exec  <= '0;
            st3_id    <= '0;
            ex_valid  <= '0;
            ex_id     <= '0;
        end else begin
            st2_valid <= next_st2_valid;
            st2_addr  <= next_st2_addr;
            st2_kind  <= next_st2_kind;
            st2_width <= next_st2_width;
            st2_exec  <= next_st2_exec;
            st2_id    <= next_st2_id;
            st3_valid <= next_st3_valid;
            st3_exec  <= next_st3_exec;
            st3_id    <= next_st3_id;
            ex_valid  <= next_ex_valid;
            ex_id     <= next_ex_id;
        end
    end

    assign dc_req_valid = st2_valid;
    assign dc_req_addr  = st2_addr;
    assign dc_req_kind  = st2_kind;
    assign dc_req_width = st2_width;
    assign dc_req_id    = st2_id;
    assign fwd_valid    = st3_valid;
    assign fwd_id       = st3_id;
    assign ieu_start    = ex_valid;
    assign ieu_id       = ex_id;
endmodule

// [test/lsq_sched_sva.sv]
// Port assertions for the load/store queue scheduler
`timescale 1ns/1ns
module lsq_sched_sva (
    input wire logic                      sys_clk,
    input wire logic                      rst_n,
    input wire logic                      disp_valid,
    input wire lsq_pkg::lsq_kind_t        disp_kind,
    input wire logic                      disp_ready,
    input wire logic                      icu_alloc,
    input wire logic                      rs_alloc,
    input wire logic                      agu_req_valid,
    input wire logic [3:0]                agu_req_idx,
    input wire logic                      dc_ready,
    input wire logic [1:0]                dc_req_valid,
    input wire lsq_pkg::lsq_kind_t [1:0]  dc_req_kind,
    input wire lsq_pkg::lsq_width_t [1:0] dc_req_width,
    input wire logic [1:0][5:0]           dc_req_id,
    input wire logic [1:0]                fwd_valid,
    input wire logic [1:0][5:0]           fwd_id,
    input wire logic [1:0]                ieu_start,
    input wire logic [1:0][5:0]           ieu_id
);
    // Entries leave at the scan edge, so a scan shows up as dc_req_valid one cycle later
    logic [4:0] occ, next_occ, live;
    always_comb begin
        live = occ - 5'(dc_req_valid[0]) - 5'(dc_req_valid[1]);
        next_occ = rst_n ? live + 5'(icu_alloc) : 5'h00;
    end
    always_ff @(posedge sys_clk) begin
        occ <= next_occ;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    property p_alloc;
        icu_alloc == (disp_valid && disp_ready && disp_kind != lsq_pkg::LSQ_OP_NONE)
            && rs_alloc == icu_alloc;
    endproperty
    a_alloc: assert property (p_alloc) else $error("allocation strobes wrong");
    property p_ready;
        disp_ready == (live < lsq_pkg::FULL_CNT);
    endproperty
    a_ready: assert property (p_ready) else $error("disp_ready vs occupancy");
    property p_agu_idx;
        agu_req_valid |-> agu_req_idx <= lsq_pkg::LAST_IDX;
    endproperty
    a_agu_idx: assert property (p_agu_idx) else $error("queue index out of range");
    property p_order;
        dc_req_valid[1] |-> dc_req_valid[0] && dc_req_id[1] != dc_req_id[0];
    endproperty
    a_order: assert property (p_order) else $error("younger slot without older");
    property p_pair;
        &dc_req_valid |-> dc_req_kind[0] < lsq_pkg::LSQ_OP_STORE
            || dc_req_kind[1] < lsq_pkg::LSQ_OP_STORE || dc_req_width == 2'h0;
    endproperty
    a_pair: assert property (p_pair) else $error("illegal store pair");
    property p_stall;
        !dc_ready |=> dc_req_valid == 2'h0;
    endproperty
    a_stall: assert property (p_stall) else $error("scan while cache stalled");
    property p_fwd;
        fwd_valid == $past(dc_req_valid);
    endproperty
    a_fwd: assert property (p_fwd) else $error("forward not one cycle after transport");
    property p_ieu;
        ieu_start[0] |-> $past(fwd_valid[0]) && ieu_id[0] == $past(dc_req_id[0], 2);
    endproperty
    a_ieu: assert property (p_ieu) else $error("integer start misplaced");
    property p_ieu1;
        ieu_start[1] |-> $past(fwd_valid[1]) && ieu_id[1] == $past(dc_req_id[1], 2);
    endproperty
    a_ieu1: assert property (p_ieu1) else $error("younger integer start misplaced");
    property p_fwd_id;
        fwd_valid[0] |-> fwd_id[0] == $past(dc_req_id[0]);
    endproperty
    a_fwd_id: assert property (p_fwd_id) else $error("forward id not carried");
endmodule
bind lsq_sched lsq_sched_sva lsq_sched_sva_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .disp_valid(disp_valid), .disp_kind(disp_kind),
    .disp_ready(disp_ready), .icu_alloc(icu_alloc), .rs_alloc(rs_alloc),
    .agu_req_valid(agu_req_valid), .agu_req_idx(agu_req_idx), .dc_ready(dc_ready),
    .dc_req_valid(dc_req_valid), .dc_req_kind(dc_req_kind), .dc_req_width(dc_req_width),
    .dc_req_id(dc_req_id), .fwd_valid(fwd_valid), .fwd_id(fwd_id), .ieu_start(ieu_start),
    .ieu_id(ieu_id));

// [test/lsq_far_model.sv]
// Address generation and data cache stand-in facing the scheduler
`timescale 1ns/1ns
module lsq_far_model (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        slow,
    input  wire logic        stall,
    input  wire logic        agu_req_valid,
    input  wire logic [3:0]  agu_req_idx,
    output logic             agu_req_ready,
    output logic [1:0]       agu_done_valid,
    output logic [1:0][3:0]  agu_done_idx,
    output logic [1:0][31:0] agu_done_addr,
    output logic             dc_ready
);
    logic [3:0] pend[$];
    logic [3:0] k;
    int         wait_c;
    assign dc_ready = !stall;
    initial begin
        {agu_req_ready, agu_done_valid, agu_done_idx, agu_done_addr} = '0;
    end
    always @(posedge sys_clk) begin
        agu_done_valid <= 2'h0;
        // Idle return lines toggle so a stale value is never mistaken for a fresh one
        agu_done_idx <= ~agu_done_idx;
        agu_done_addr <= ~agu_done_addr;
        if (!rst_n) begin
            pend.delete();
            wait_c = 0;
        end else begin
            if (wait_c > 0) begin
                wait_c = wait_c - 1;
            end else if (pend.size() != 0) begin
                k = pend.pop_back();
                agu_done_valid[k[0]] <= 1'b1;
                agu_done_idx[k[0]] <= k;
                agu_done_addr[k[0]] <= {28'hA000000, k};
                wait_c = slow ? 3 : 0;
            end
            if (agu_req_valid && agu_req_ready) pend.push_back(agu_req_idx);
        end
        agu_req_ready <= rst_n && pend.size() < 3;
    end
endmodule

// [test/lsq_sched_tb.sv]
// Self-checking bench for the load/store queue scheduler
`timescale 1ns/1ns
module lsq_sched_tb;
    // Row bits: kind a, width a, kind b, width b, exec b | expected first scan slots
    localparam logic [8:0] ROWS [8] = '{9'h0DF, 9'h0EB, 9'h123, 9'h169,
                                        9'h137, 9'h1E5, 9'h15F, 9'h093};
    logic sys_clk, rst_n, disp_valid, disp_exec, disp_src_ready, disp_ready, icu_alloc;
    logic rs_alloc, res_valid, agu_req_valid, agu_req_ready, dc_ready, slow, stall;
    lsq_pkg::lsq_kind_t        disp_kind;
    lsq_pkg::lsq_width_t       disp_width;
    logic [5:0]                disp_id, disp_src_tag, res_tag, nid;
    logic [3:0]                agu_req_idx;
    logic [1:0]                agu_done_valid, dc_req_valid, fwd_valid, ieu_start;
    logic [1:0][3:0]           agu_done_idx;
    logic [1:0][31:0]          agu_done_addr, dc_req_addr;
    lsq_pkg::lsq_kind_t [1:0]  dc_req_kind;
    lsq_pkg::lsq_width_t [1:0] dc_req_width;
    logic [1:0][5:0]           dc_req_id, fwd_id, ieu_id;
    logic [5:0]                exp_ids[$], got_ids[$];
    int                        n_fail, checks, cyc, n_ieu, exp_ieu;
    lsq_sched lsq_sched_i (.sys_clk(sys_clk), .rst_n(rst_n), .disp_valid(disp_valid),
        .disp_kind(disp_kind), .disp_width(disp_width), .disp_exec(disp_exec),
        .disp_id(disp_id), .disp_src_ready(disp_src_ready), .disp_src_tag(disp_src_tag),
        .disp_ready(disp_ready), .icu_alloc(icu_alloc), .rs_alloc(rs_alloc),
        .res_valid(res_valid), .res_tag(res_tag), .agu_req_valid(agu_req_valid),
        .agu_req_idx(agu_req_idx), .agu_req_ready(agu_req_ready),
        .agu_done_valid(agu_done_valid), .agu_done_idx(agu_done_idx),
        .agu_done_addr(agu_done_addr), .dc_ready(dc_ready), .dc_req_valid(dc_req_valid),
        .dc_req_addr(dc_req_addr), .dc_req_kind(dc_req_kind), .dc_req_width(dc_req_width),
        .dc_req_id(dc_req_id), .fwd_valid(fwd_valid), .fwd_id(fwd_id),
        .ieu_start(ieu_start), .ieu_id(ieu_id));
    lsq_far_model lsq_far_model_i (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow),
        .stall(stall), .agu_req_valid(agu_req_valid), .agu_req_idx(agu_req_idx),
        .agu_req_ready(agu_req_ready), .agu_done_valid(agu_done_valid),
        .agu_done_idx(agu_done_idx), .agu_done_addr(agu_done_addr), .dc_ready(dc_ready));
    always #20 sys_clk = ~sys_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        if (n_fail == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Leaves disp_valid high so back-to-back offers never assign it twice in one step
    task automatic disp(input logic [1:0] k, input logic w, input logic x, input logic sr);
        disp_valid <= 1'b1;
        disp_kind <= lsq_pkg::lsq_kind_t'(k);
        disp_width <= lsq_pkg::lsq_width_t'(w);
        disp_exec <= x;
        disp_src_ready <= sr;
        disp_id <= nid;
        do @(negedge sys_clk); while (disp_ready !== 1'b1);
        @(posedge sys_clk);
        exp_ids.push_back(nid);
        nid++;
    endtask
    always @(negedge sys_clk) begin
        if (dc_req_valid[0] === 1'b1) got_ids.push_back(dc_req_id[0]);
        if (dc_req_valid[1] === 1'b1) got_ids.push_back(dc_req_id[1]);
        n_ieu += int'(ieu_start[0] === 1'b1) + int'(ieu_start[1] === 1'b1);
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            end_sim();
        end
    end
    initial begin
        sys_clk = 1'b0;
        {rst_n, disp_valid, disp_exec, disp_src_ready, res_valid, slow, stall} = '0;
        {disp_id, disp_src_tag, res_tag, nid} = '0;
        disp_kind = lsq_pkg::LSQ_OP_NONE;
        disp_width = lsq_pkg::LSQ_W32;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(negedge sys_clk);
        chk(disp_ready, 1'b1);
        chk(dc_req_valid, 2'h0);
        @(posedge sys_clk);
        disp_valid <= 1'b1;
        @(negedge sys_clk);
        chk(icu_alloc, 1'b0);
        @(posedge sys_clk);
        foreach (ROWS[i]) begin
            stall <= 1'b1;
            slow <= i[0];
            disp(ROWS[i][8:7], ROWS[i][6], 1'b0, 1'b1);
            disp(ROWS[i][5:4], ROWS[i][3], ROWS[i][2], 1'b1);
            exp_ieu += int'(ROWS[i][8:7] == 2'h3) + int'(ROWS[i][5:4] == 2'h3 || ROWS[i][2]);
            disp_valid <= 1'b0;
            repeat (16) @(posedge sys_clk);
            stall <= 1'b0;
            do @(negedge sys_clk); while (dc_req_valid === 2'h0);
            chk(dc_req_valid, ROWS[i][1:0]);
            chk(dc_req_addr[0], {28'hA000000, 4'((2 * i) % 12)});
            chk(dc_req_kind[0], ROWS[i][8:7]);
            if (ROWS[i][1]) chk(dc_req_addr[1], {28'hA000000, 4'((2 * i) % 12 + 1)});
            @(posedge sys_clk);
        end
        // Fill with operands outstanding, then release the producer result
        stall <= 1'b1;
        slow <= 1'b0;
        repeat (12) disp(2'h1, 1'b1, 1'b0, 1'b0);
        fork
            disp(2'h1, 1'b0, 1'b0, 1'b1);
            begin
                @(negedge sys_clk);
                chk(disp_ready, 1'b0);
                chk(icu_alloc, 1'b0);
                chk(agu_req_valid, 1'b0);
                @(posedge sys_clk);
                res_valid <= 1'b1;
                stall <= 1'b0;
                @(posedge sys_clk);
                res_valid <= 1'b0;
            end
        join
        disp_valid <= 1'b0;
        repeat (40) @(posedge sys_clk);
        chk(got_ids.size(), exp_ids.size());
        foreach (got_ids[i]) chk(got_ids[i], exp_ids[i]);
        chk(n_ieu, exp_ieu);
        // Address returned in a cycle lets the head scan in that same cycle
        disp(2'h1, 1'b1, 1'b0, 1'b1);
        disp_valid <= 1'b0;
        repeat (3) @(negedge sys_clk);
        chk(dc_req_valid, 2'h0);
        @(negedge sys_clk);
        chk(dc_req_valid, 2'h1);
        // Mid-run reset must drop a queued entry, so a later result cannot wake it
        @(posedge sys_clk);
        disp(2'h2, 1'b0, 1'b0, 1'b0);
        disp_valid <= 1'b0;
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        res_valid <= 1'b1;
        @(negedge sys_clk);
        chk(dc_req_valid, 2'h0);
        @(posedge sys_clk);
        res_valid <= 1'b0;
        @(negedge sys_clk);
        chk(agu_req_valid, 1'b0);
        @(posedge sys_clk);
        end_sim();
    end
endmodule
